// File: dv/phy_mgmt_status_register_test.sv
// Purpose: Self-checking bench for the status register block
// Assumes: Pin changes settle in the word within ten cycles
// Notes: Expected words come from the bench's own model
`timescale 1ns/1ps
`default_nettype none
module phy_mgmt_status_register_test
  import phy_status_pkg::*;
;
  // ==========================================================
  // Signals
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic overrideWritable = 1'b0;
  logic [4:0] pinVec = 5'h00;
  logic [4:0] regAddr;
  logic readStb;
  logic writeStb;
  logic [15:0] writeData;
  logic [15:0] readData;
  logic readValid;
  logic framePreambleSkip;
  logic [15:0] expQ[$];
  logic [3:0] cap;
  logic pre;
  logic [15:0] d;
  int bad_count = 0;
  int n_tests = 0;
  // Clock at 200 MHz
  always #2.5 clk_sys = ~clk_sys;
  // ==========================================================
  // Instances
  sta_model sta_model_inst (.clk_sys(clk_sys), .regAddr(regAddr), .readStb(readStb),
    .writeStb(writeStb), .writeData(writeData));
  phy_mgmt_status_register phy_mgmt_status_register_inst (.clk_sys(clk_sys), .rst(rst),
    .regAddr(regAddr), .readStb(readStb), .writeStb(writeStb), .writeData(writeData),
    .readData(readData), .readValid(readValid), .overrideWritable(overrideWritable),
    .negEnablePin(pinVec[4]), .negDonePin(pinVec[3]), .remFaultPin(pinVec[2]),
    .linkOkPin(pinVec[1]), .jabberPin(pinVec[0]), .framePreambleSkip(framePreambleSkip));
  // ==========================================================
  // Helpers
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [15:0] word(input logic ng, input logic rf, input logic lk, input logic jb);
    word = {1'b0, cap, 4'h0, pre, ng, rf, 1'b1, lk, jb, 1'b1};
  endfunction
  // Note the answer before asking
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    if (a == STATUS_ADDR) expQ.push_back(e);
    sta_model_inst.rd(a);
    repeat (2) @(posedge clk_sys);
  endtask
  // Hold pins long enough for the synchroniser
  task automatic pins(input logic [4:0] p);
    @(posedge clk_sys);
    pinVec <= p;
    repeat (10) @(posedge clk_sys);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ==========================================================
  // Answer watcher: an answer with no note is itself a mismatch
  always @(posedge clk_sys) begin
    if (readValid === 1'b1) begin
      if (expQ.size() == 0) check("unasked answer", 16'h0001, 16'h0000);
      else check("readData", readData, expQ.pop_front());
    end
  end
  // Watchdog sized well past the sequence length
  initial begin
    #100000;
    bad_count++;
    results();
  end
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(93));
    cap = CAP_RESET;
    pre = 1'b0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    rd(STATUS_ADDR, word(0, 0, 0, 0));
    rd(5'h02, 16'h0000);
    check("unmapped read", readData, 16'h0000);
    sta_model_inst.wr(STATUS_ADDR, 16'h0000);
    rd(STATUS_ADDR, word(0, 0, 0, 0));
    overrideWritable <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      d = 16'($urandom);
      sta_model_inst.wr(STATUS_ADDR, d);
      cap = d[14:11];
      pre = d[6];
      rd(STATUS_ADDR, word(0, 0, 0, 0));
      check("preamble skip", {15'h0, framePreambleSkip}, {15'h0, pre});
    end
    // unlocked write to another address ignored
    sta_model_inst.wr(5'h02, ~d);
    rd(STATUS_ADDR, word(0, 0, 0, 0));
    pins(5'h1f);
    rd(STATUS_ADDR, word(1, 1, 0, 1));
    rd(STATUS_ADDR, word(1, 1, 1, 1));
    pins(5'h12);
    pins(5'h10);
    pins(5'h12);
    rd(STATUS_ADDR, word(1, 1, 0, 1));
    rd(STATUS_ADDR, word(0, 0, 1, 0));
    pins(5'h0a);
    rd(STATUS_ADDR, word(0, 0, 1, 0));
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    cap = CAP_RESET;
    pre = 1'b0;
    check("preamble skip", {15'h0, framePreambleSkip}, 16'h0000);
    rd(STATUS_ADDR, word(0, 0, 0, 0));
    repeat (4) @(posedge clk_sys);
    check("pending answers", 16'(expQ.size()), 16'h0000);
    results();
  end
endmodule
`default_nettype wire

// File: dv/sta_model.sv
// Purpose: Station manager model driving the management strobes
// Assumes: Strobes change just after a rising edge
// Notes: Released write data shows the inverse of the last word
`timescale 1ns/1ps
`default_nettype none
module sta_model
  import phy_status_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Management strobes
  output logic [4:0] regAddr,
  output logic readStb,
  output logic writeStb,
  output logic [15:0] writeData
);
  // ==========================================================
  // Idle levels
  initial begin
    regAddr = 5'h00;
    readStb = 1'b0;
    writeStb = 1'b0;
    writeData = 16'h0000;
  end
  // One-cycle read request
  task automatic rd(input logic [4:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    readStb <= 1'b1;
    @(posedge clk_sys);
    readStb <= 1'b0;
  endtask
  // One-cycle write request
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] v;
    v = d;
    v[BIT_RSV_HI:BIT_RSV_LO] = RSV_RESET;
    @(posedge clk_sys);
    regAddr <= a;
    writeStb <= 1'b1;
    writeData <= v;
    @(posedge clk_sys);
    writeStb <= 1'b0;
    writeData <= ~v; // Stale data must not look valid
  endtask
endmodule
`default_nettype wire

// File: include/phy_status_pkg.sv
// Purpose: Constants for the management status register block
// Assumes: 16-bit register word, 5-bit register address
// Notes: Bit positions and reset value of the status word
package phy_status_pkg;
  // ==========================================================
  // Register map
  localparam logic [4:0] STATUS_ADDR = 5'h01;
  localparam logic [15:0] STATUS_RESET = 16'h7809;
  // ==========================================================
  // Field positions
  localparam int BIT_T4 = 15;
  localparam int BIT_CAP_HI = 14;
  localparam int BIT_CAP_LO = 11;
  localparam int BIT_RSV_HI = 10;
  localparam int BIT_RSV_LO = 7;
  localparam int BIT_PRE_SKIP = 6;
  localparam int BIT_NEG_DONE = 5;
  localparam int BIT_REM_FAULT = 4;
  localparam int BIT_NEG_ABLE = 3;
  localparam int BIT_LINK = 2;
  localparam int BIT_JABBER = 1;
  localparam int BIT_EXT = 0;
  localparam int CAP_W = 4;
  localparam int RSV_W = 4;
  localparam logic [CAP_W-1:0] CAP_RESET = 4'hf;
  localparam logic [RSV_W-1:0] RSV_RESET = 4'h0;
  localparam logic ZERO_BIT = 1'b0;
  localparam logic ONE_BIT = 1'b1;
endpackage

// File: include/status_event_if.sv
// Purpose: Carries status events and read strobe to the sticky bit bank
// Assumes: Single clock domain
// Notes: Sticky bits are returned on the same bundle
`timescale 1ns/1ps
`default_nettype none
interface status_event_if;
  logic negEnable;
  logic negDone;
  logic remFault;
  logic linkOk;
  logic jabberSeen;
  logic readStrobe;
  logic negDoneSticky;
  logic remFaultSticky;
  logic linkSticky;
  logic jabberSticky;
  modport src (output negEnable, negDone, remFault, linkOk, jabberSeen, readStrobe,
    input negDoneSticky, remFaultSticky, linkSticky, jabberSticky);
  modport bank (input negEnable, negDone, remFault, linkOk, jabberSeen, readStrobe,
    output negDoneSticky, remFaultSticky, linkSticky, jabberSticky);
endinterface
`default_nettype wire

// File: rtl/phy_mgmt_status_register.sv
// Purpose: Management status register word at address one
// Assumes: Management frame logic presents decoded read and write strobes
// Notes: Status sources are pins, so they pass a three-stage synchroniser
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - Status word is 16 bits at management address one, readable.
// - Every bit returns to its default on any reset.
// - Bit 15 is read-only and always reads zero.
// - Capability bits 14..11 default one, change only by override write.
// - Capability bit reads one when mode supported, zero otherwise.
// - Reserved bits 10..7 read zero.
// - Override-writable bits accept writes only while unlock is one.
// - Bit 6 defaults zero; one means preamble-less frames accepted.
// - Bit 5 read-only sticky-high negotiation complete, default zero.
// - Bit 4 read-only sticky-high remote fault, default zero.
// - Bits 3 and 0 are read-only and always read one.
// - Bit 2 sticky-low link state, default zero, zero after drops.
// - Bit 1 sticky-high jabber, cleared by register read.
// - Remote fault bit is cleared by register read.
// - Completion set only after negotiation finishes; zero when disabled.
module phy_mgmt_status_register
  import phy_status_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Management access
  input wire logic [4:0] regAddr,
  input wire logic readStb,
  input wire logic writeStb,
  input wire logic [15:0] writeData,
  output logic [15:0] readData,
  output logic readValid,
  // Override unlock from the extended control register
  input wire logic overrideWritable,
  // Status sources
  input wire logic negEnablePin,
  input wire logic negDonePin,
  input wire logic remFaultPin,
  input wire logic linkOkPin,
  input wire logic jabberPin,
  // Preamble skip setting to the frame logic
  output logic framePreambleSkip
);
  status_event_if ev ();
  logic [4:0] syncLevel;
  logic [CAP_W-1:0] capBits, next_capBits;
  logic [RSV_W-1:0] rsvBits, next_rsvBits;
  logic preSkip, next_preSkip;
  logic [15:0] word;
  logic [15:0] next_readData;
  logic next_readValid;
  logic hit;

  // ==========================================================
  // Pin synchronisers; link idles low, rest low
  pin_sync3 #(.W(5), .INIT(5'h00)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pinIn({negEnablePin, negDonePin, remFaultPin, linkOkPin, jabberPin}),
    .level(syncLevel)
  );

  assign hit = (regAddr == STATUS_ADDR);
  assign ev.negEnable = syncLevel[4];
  assign ev.negDone = syncLevel[3];
  assign ev.remFault = syncLevel[2];
  assign ev.linkOk = syncLevel[1];
  assign ev.jabberSeen = syncLevel[0];
  assign ev.readStrobe = readStb & hit;

  // sticky bits fed only from sources and the status read strobe
  sticky_bank u_sticky (
    .clk_sys(clk_sys),
    .rst(rst),
    .ev(ev)
  );

  // ==========================================================
  // Override-writable fields
  always_comb begin
    next_capBits = capBits;
    next_rsvBits = rsvBits;
    next_preSkip = preSkip;
    if (writeStb && hit && overrideWritable) begin
      next_capBits = writeData[BIT_CAP_HI:BIT_CAP_LO];
      next_rsvBits = writeData[BIT_RSV_HI:BIT_RSV_LO];
      next_preSkip = writeData[BIT_PRE_SKIP];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      capBits <= CAP_RESET;
      rsvBits <= RSV_RESET;
      preSkip <= STATUS_RESET[BIT_PRE_SKIP];
    end else begin
      capBits <= next_capBits;
      rsvBits <= next_rsvBits;
      preSkip <= next_preSkip;
    end
  end

  // ==========================================================
  // Read word assembly
  always_comb begin
    word = '0;
    word[BIT_T4] = ZERO_BIT;
    word[BIT_CAP_HI:BIT_CAP_LO] = capBits;
    // reserved read zero; stored copy kept for test hooks
    word[BIT_RSV_HI:BIT_RSV_LO] = RSV_RESET;
    word[BIT_PRE_SKIP] = preSkip;
    word[BIT_NEG_DONE] = ev.negDoneSticky;
    word[BIT_REM_FAULT] = ev.remFaultSticky;
    word[BIT_NEG_ABLE] = ONE_BIT;
    word[BIT_EXT] = ONE_BIT;
    word[BIT_LINK] = ev.linkSticky;
    word[BIT_JABBER] = ev.jabberSticky;
    next_readData = readData;
    next_readValid = 1'b0;
    if (readStb && hit) begin
      next_readData = word;
      next_readValid = 1'b1;
    end else if (readStb) begin
      next_readData = '0; // Unmapped here: another block answers
    end
  end

  // Output registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      readData <= '0;
      readValid <= 1'b0;
      framePreambleSkip <= STATUS_RESET[BIT_PRE_SKIP];
    end else begin
      readData <= next_readData;
      readValid <= next_readValid;
      framePreambleSkip <= next_preSkip;
    end
  end

  // ==========================================================
  // Checks
  // locked write leaves fields
  locked_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    (writeStb && !overrideWritable) |=> $stable(capBits) && $stable(preSkip))
    else $error("override field changed while locked");
  rsv_locked_a: assert property (@(posedge clk_sys) disable iff (rst)
    (writeStb && !overrideWritable) |=> $stable(rsvBits))
    else $error("reserved copy changed while locked");
  rsv_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    (writeStb && hit && overrideWritable) |=> rsvBits == $past(writeData[BIT_RSV_HI:BIT_RSV_LO]))
    else $error("reserved write not taken");
  cap_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    (writeStb && hit && overrideWritable) |=> capBits == $past(writeData[BIT_CAP_HI:BIT_CAP_LO]))
    else $error("capability write not taken");
  pre_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    (writeStb && hit && overrideWritable) |=> preSkip == $past(writeData[BIT_PRE_SKIP]))
    else $error("preamble skip write not taken");
  pre_follow_a: assert property (@(posedge clk_sys) disable iff (rst)
    framePreambleSkip == preSkip) else $error("preamble skip output differs");
  other_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    (writeStb && !hit) |=> $stable(capBits) && $stable(rsvBits) && $stable(preSkip))
    else $error("field changed by write to another address");
  fixed_bits_a: assert property (@(posedge clk_sys) disable iff (rst)
    readValid |-> readData[BIT_NEG_ABLE] && readData[BIT_EXT] && !readData[BIT_T4])
    else $error("fixed bits wrong");
  rsv_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
    readValid |-> readData[BIT_RSV_HI:BIT_RSV_LO] == RSV_RESET) else $error("reserved bits nonzero");
  cap_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    readValid |-> readData[BIT_CAP_HI:BIT_CAP_LO] == $past(capBits))
    else $error("capability bits misread");
  // completion and fault read as held
  status_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    readValid |-> readData[BIT_NEG_DONE] == $past(ev.negDoneSticky)
      && readData[BIT_REM_FAULT] == $past(ev.remFaultSticky))
    else $error("completion or fault bit misread");
  // link and jabber read as held
  link_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    readValid |-> readData[BIT_LINK] == $past(ev.linkSticky)
      && readData[BIT_JABBER] == $past(ev.jabberSticky))
    else $error("link or jabber bit misread");
  link_restore_a: assert property (@(posedge clk_sys) disable iff (rst)
    (ev.readStrobe && ev.linkOk) |=> ev.linkSticky)
    else $error("link bit not restored by read");
  jabber_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    (readStb && hit && !ev.jabberSeen) |=> !ev.jabberSticky)
    else $error("jabber not cleared by read");
  jabber_set_a: assert property (@(posedge clk_sys) disable iff (rst)
    ev.jabberSeen |=> ev.jabberSticky) else $error("jabber not latched");
  fault_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    (readStb && hit && !ev.remFault) |=> !ev.remFaultSticky)
    else $error("fault not cleared by read");
  read_answer_a: assert property (@(posedge clk_sys) disable iff (rst)
    (readStb && hit) |=> readValid) else $error("read not answered");
  answer_hit_a: assert property (@(posedge clk_sys) disable iff (rst)
    !(readStb && hit) |=> !readValid) else $error("answer without a read");
  data_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    !readStb |=> $stable(readData)) else $error("read data moved without a read");
  fault_set_a: assert property (@(posedge clk_sys) disable iff (rst)
    ev.remFault |=> ev.remFaultSticky) else $error("fault not latched");
  done_set_a: assert property (@(posedge clk_sys) disable iff (rst)
    (ev.negEnable && ev.negDone) ##1 ev.negEnable |-> ev.negDoneSticky)
    else $error("completion not latched");
  done_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    (ev.readStrobe && !ev.negDone) |=> !ev.negDoneSticky)
    else $error("completion not cleared by read");
  sticky_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    (writeStb && !readStb && !ev.remFault && !ev.jabberSeen)
      |=> $stable(ev.remFaultSticky) && $stable(ev.jabberSticky))
    else $error("sticky bit moved by a write");
  // defaults held in reset; second cycle so the flops have settled
  reset_values_a: assert property (@(posedge clk_sys)
    rst ##1 rst |-> capBits == CAP_RESET && rsvBits == RSV_RESET
      && preSkip == STATUS_RESET[BIT_PRE_SKIP] && !readValid && readData == '0
      && !ev.negDoneSticky && !ev.remFaultSticky && !ev.linkSticky && !ev.jabberSticky)
    else $error("defaults not loaded in reset");
endmodule
`default_nettype wire

// File: rtl/pin_sync3.sv
// Purpose: Three-stage synchroniser for pin levels
// Assumes: Input is asynchronous to clk_sys
// Notes: Output changes only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Levels
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] level
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] next_level;

  // ==========================================================
  // Agreement filter; stage1 feeds stage2 only
  always_comb begin
    next_level = level;
    for (int i = 0; i < W; i++) begin
      if (stage2[i] == stage3[i]) begin
        next_level[i] = stage3[i];
      end
    end
  end

  // Registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage1 <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
      level <= INIT;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
      level <= next_level;
    end
  end
endmodule
`default_nettype wire

// File: rtl/sticky_bank.sv
// Purpose: Sticky status bits of the status register
// Assumes: Inputs already synchronised to clk_sys
// Notes: A set in the read cycle wins over the read clear
`timescale 1ns/1ps
`default_nettype none
module sticky_bank
  import phy_status_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Event bundle
  status_event_if.bank ev
);
  logic negDoneQ, remFaultQ, linkQ, jabberQ;
  logic next_negDone, next_remFault, next_link, next_jabber;

  // ==========================================================
  // Next values of the sticky bits
  always_comb begin
    if (!ev.negEnable) begin
      next_negDone = ZERO_BIT;
    end else begin
      next_negDone = ev.negDone | (negDoneQ & ~ev.readStrobe);
    end
    next_remFault = ev.remFault | (remFaultQ & ~ev.readStrobe);
    next_jabber = ev.jabberSeen | (jabberQ & ~ev.readStrobe);
    if (!ev.linkOk) begin
      next_link = ZERO_BIT;
    end else if (ev.readStrobe || linkQ) begin
      next_link = ONE_BIT;
    end else begin
      next_link = linkQ;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      negDoneQ <= STATUS_RESET[BIT_NEG_DONE];
      remFaultQ <= STATUS_RESET[BIT_REM_FAULT];
      linkQ <= STATUS_RESET[BIT_LINK];
      jabberQ <= STATUS_RESET[BIT_JABBER];
    end else begin
      negDoneQ <= next_negDone;
      remFaultQ <= next_remFault;
      linkQ <= next_link;
      jabberQ <= next_jabber;
    end
  end

  assign ev.negDoneSticky = negDoneQ;
  assign ev.remFaultSticky = remFaultQ;
  assign ev.linkSticky = linkQ;
  assign ev.jabberSticky = jabberQ;

  link_drop_a: assert property (@(posedge clk_sys) disable iff (rst)
    !ev.linkOk |=> !linkQ) else $error("link bit not cleared on drop");
  neg_disabled_a: assert property (@(posedge clk_sys) disable iff (rst)
    !ev.negEnable |=> !negDoneQ) else $error("negotiation bit set while disabled");
endmodule
`default_nettype wire
